/* dv/crtr_host.sv */
// Host processor model that drives the I/O port of the register set.
`timescale 1ns/1ns
module crtr_host
    import crtr_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Host bus
    input wire logic [7:0] i_host_data_bus,
    input wire logic i_host_data_oe,
    output logic [3:0] o_port,
    output logic [7:0] o_data,
    output logic o_wr,
    output logic o_rd
);
    initial begin
        o_port = 4'hA;
        o_data = 8'hFF;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // Port and data stay put until the storing edge; data then turns over.
    task automatic wr(input logic [3:0] p, input logic [7:0] d);
        @(posedge i_clk);
        o_port <= p;
        o_data <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_data <= ~d;
        #1;
    endtask
    task automatic rd(input logic [3:0] p, output logic [7:0] d, output logic oe);
        @(posedge i_clk);
        o_port <= p;
        o_rd <= 1'b1;
        @(posedge i_clk);
        d = i_host_data_bus;
        oe = i_host_data_oe;
        o_rd <= 1'b0;
    endtask
    task automatic reg_wr(input logic [4:0] idx, input logic [7:0] d);
        wr(4'h0, {3'h0, idx});
        wr(4'h1, d);
    endtask
endmodule

/* dv/crtr_regs_chk.sv */
// Concurrent checks on the host port of the raster timing register set.
`timescale 1ns/1ns
module crtr_regs_chk
    import crtr_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // Host port
    input wire logic [3:0] i_port_select_lines,
    input wire logic [7:0] i_host_data_bus,
    input wire logic [7:0] o_host_data_bus,
    input wire logic o_host_data_oe,
    input wire logic o_bus_direction,
    input wire logic i_io_write_strobe,
    input wire logic i_io_read_strobe,
    input wire logic i_bank_port_selectn,
    // Personality, pen and register values
    input wire logic i_mono_personality,
    input wire logic i_pen_strobe,
    input wire logic [4:0] o_vsync_width,
    input wire logic [7:0] o_operating_mode,
    input wire logic [7:0] o_control_identity,
    input wire logic [7:0] o_bank_value,
    input wire logic o_bank_write,
    input wire logic o_compat_variant_select,
    input wire logic o_pen_flag
);
    logic wr_en;
    logic rd_en;
    logic [3:0] prt;
    assign wr_en = i_ce && i_io_write_strobe;
    assign rd_en = i_io_read_strobe;
    assign prt = i_port_select_lines;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    sequence s_bank_wr;
        wr_en && prt == 4'hE;
    endsequence
    sequence s_bank_open;
        !i_bank_port_selectn && o_control_identity[7];
    endsequence
    chk_bank_accept: assert property (s_bank_wr ##0 s_bank_open |=>
        o_bank_write && o_bank_value == $past(i_host_data_bus)) else $error("bank write lost");
    chk_bank_refuse: assert property (wr_en && prt == 4'hE &&
        (i_bank_port_selectn || !o_control_identity[7]) |=> !o_bank_write)
        else $error("bank write taken");
    chk_wo_quiet: assert property (rd_en && (prt inside {4'hB, 4'hC, 4'hD, 4'hE} ||
        prt[3:0] == {1'b0, prt[2:1], 1'b0}) |-> !o_host_data_oe && !o_bus_direction)
        else $error("write-only port drove bus");
    chk_status_read: assert property (rd_en && prt == 4'hA |-> o_host_data_oe &&
        o_host_data_bus == {6'h00, o_pen_flag, 1'b0}) else $error("status read wrong");
    chk_ctrl_read: assert property (rd_en && prt == 4'hF |-> o_host_data_oe &&
        o_host_data_bus == o_control_identity) else $error("control read wrong");
    chk_dir_follows: assert property (o_host_data_oe |-> rd_en && o_bus_direction)
        else $error("bus driven without read");
    chk_mode_store: assert property (wr_en && prt == 4'h8 && !i_mono_personality |=>
        o_operating_mode == $past(i_host_data_bus)) else $error("mode not stored");
    chk_pen_clear: assert property (wr_en && prt == 4'hB && !$rose(i_pen_strobe) |=>
        !o_pen_flag) else $error("pen flag not cleared");
    chk_pen_preset: assert property (wr_en && prt == (i_mono_personality ? 4'h9 : 4'hC)
        |=> o_pen_flag) else $error("pen flag not preset");
    chk_pen_capture: assert property (i_ce && $rose(i_pen_strobe) |=> o_pen_flag)
        else $error("pen capture missed");
    chk_vsync_fixed: assert property (!o_compat_variant_select |-> o_vsync_width == 5'h10)
        else $error("vertical sync width not fixed");
endmodule
bind crtr_regs crtr_regs_chk chk_u (.i_clk, .i_resetn, .i_ce, .i_port_select_lines,
    .i_host_data_bus, .o_host_data_bus, .o_host_data_oe, .o_bus_direction,
    .i_io_write_strobe, .i_io_read_strobe, .i_bank_port_selectn, .i_mono_personality,
    .i_pen_strobe, .o_vsync_width, .o_operating_mode, .o_control_identity, .o_bank_value,
    .o_bank_write, .o_compat_variant_select, .o_pen_flag);

/* dv/crtr_regs_tb.sv */
// Self-checking testbench of the raster timing register set.
`timescale 1ns/1ns
module crtr_regs_tb;
    import crtr_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic bank_seln = 1'b1;
    logic mono = 1'b0;
    logic pen = 1'b0;
    logic [13:0] raddr = 14'h0000;
    logic [3:0] port;
    logic [7:0] wdat, rdat, htot, hdisp, vtot, mode, got, hsp, vdsp, vsp, csel;
    logic [3:0] hw;
    logic [4:0] vw, vadj, maxr;
    logic [4:0] rast = 5'h00;
    logic [5:0] bptr;
    logic [13:0] saddr, caddr;
    logic fstart = 1'b0;
    logic amatch = 1'b0;
    logic wr, rd, oe, ilace, var_sel, flag, got_oe, cur;
    int err_count = 0;
    int checks = 0;
    always #5 clk = ~clk;
    crtr_host host_u (.i_clk(clk), .i_host_data_bus(rdat), .i_host_data_oe(oe),
        .o_port(port), .o_data(wdat), .o_wr(wr), .o_rd(rd));
    crtr_regs dut_u (.i_clk(clk), .i_resetn(resetn), .i_ce(ce), .i_port_select_lines(port),
        .i_host_data_bus(wdat), .o_host_data_bus(rdat), .o_host_data_oe(oe),
        .o_bus_direction(), .i_io_write_strobe(wr), .i_io_read_strobe(rd),
        .i_bank_port_selectn(bank_seln), .i_mono_personality(mono), .i_pen_strobe(pen),
        .i_refresh_addr(raddr), .i_field_start(fstart), .i_raster(rast),
        .i_cursor_addr_match(amatch), .o_htotal(htot), .o_hdisp(hdisp), .o_hsync_pos(hsp),
        .o_hsync_width(hw), .o_vsync_width(vw), .o_vtotal(vtot), .o_vadjust(vadj),
        .o_vdisp(vdsp), .o_vsync_pos(vsp), .o_interlace(ilace), .o_max_raster(maxr),
        .o_start_addr(saddr), .o_cursor_addr(caddr), .o_cursor_on(cur),
        .o_operating_mode(mode), .o_colour_select(csel), .o_control_identity(),
        .o_bank_pointer(bptr), .o_bank_value(),
        .o_bank_write(), .o_compat_variant_select(var_sel), .o_pen_flag(flag));
    task automatic end_sim();
        $display("Checks %0d, errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic rdchk(input logic [3:0] p, input logic [8:0] e);
        host_u.rd(p, got, got_oe);
        cmp(16'({got_oe, got}), 16'(e));
    endtask
    task automatic bank(input logic [5:0] idx, input logic [7:0] v);
        host_u.wr(4'hD, {2'h0, idx});
        host_u.wr(4'hE, v);
    endtask
    task automatic do_reset();
        @(posedge clk);
        resetn <= 1'b0;
        bank_seln <= 1'b1;
        mono <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        #1;
    endtask
    task automatic t_reset();
        cmp(16'(var_sel), 16'h0000);
        cmp(16'(vw), 16'h0010);
        rdchk(4'hA, 9'h100);
        rdchk(4'hF, 9'h100);
        rdchk(4'h8, 9'h000);
        rdchk(4'hB, 9'h000);
        rdchk(4'h0, 9'h000);
        $display("t_reset done");
    endtask
    task automatic t_addr();
        host_u.reg_wr(5'h0C, 8'hFF);
        host_u.wr(4'h6, 8'h0D);
        host_u.wr(4'h7, 8'hA5);
        cmp(16'(saddr), 16'h3FA5);
        rdchk(4'h3, 9'h1A5);
        rdchk(4'h5, 9'h1A5);
        host_u.reg_wr(5'h00, 8'h70);
        rdchk(4'h1, 9'h100);
        $display("t_addr done");
    endtask
    task automatic t_horiz();
        host_u.reg_wr(5'h01, 8'h51);
        cmp(16'(htot), 16'h0070);
        cmp(16'(hdisp), 16'h0051);
        host_u.wr(4'h8, 8'h01);
        cmp(16'(htot), 16'h0071);
        cmp(16'(hdisp), 16'h0050);
        host_u.wr(4'h8, 8'h00);
        host_u.reg_wr(5'h08, 8'h01);
        cmp(16'(ilace), 16'h0001);
        cmp(16'(htot), 16'h0071);
        host_u.reg_wr(5'h08, 8'h00);
        cmp(16'(ilace), 16'h0000);
        host_u.reg_wr(5'h03, 8'hA5);
        cmp(16'(hw), 16'h0005);
        cmp(16'(vw), 16'h0010);
        host_u.reg_wr(5'h04, 8'hFF);
        cmp(16'(vtot), 16'h007F);
        host_u.reg_wr(5'h05, 8'h1F);
        cmp(16'(vadj), 16'h001F);
        host_u.reg_wr(5'h09, 8'h0D);
        cmp(16'(maxr), 16'h000D);
        @(posedge clk);
        ce <= 1'b0;
        host_u.wr(4'h8, 8'h55);
        @(posedge clk);
        ce <= 1'b1;
        #1;
        cmp(16'(mode), 16'h0000);
        $display("t_horiz done");
    endtask
    task automatic t_pen();
        @(posedge clk);
        raddr <= 14'h2345;
        pen <= 1'b1;
        @(posedge clk);
        #1;
        cmp(16'(flag), 16'h0001);
        @(posedge clk);
        pen <= 1'b0;
        rdchk(4'hA, 9'h102);
        host_u.wr(4'h0, 8'h10);
        rdchk(4'h1, 9'h123);
        host_u.wr(4'h0, 8'h11);
        rdchk(4'h1, 9'h145);
        host_u.wr(4'hB, 8'h5A);
        cmp(16'(flag), 16'h0000);
        host_u.wr(4'hC, 8'h00);
        cmp(16'(flag), 16'h0001);
        host_u.wr(4'hB, 8'h00);
        @(posedge clk);
        mono <= 1'b1;
        host_u.wr(4'hC, 8'h00);
        cmp(16'(flag), 16'h0000);
        host_u.wr(4'h9, 8'h3C);
        cmp(16'(flag), 16'h0001);
        @(posedge clk);
        mono <= 1'b0;
        $display("t_pen done");
    endtask
    task automatic cur_at(input logic m, input logic [4:0] r, input logic e);
        @(posedge clk);
        rast <= r;
        amatch <= m;
        @(posedge clk);
        #1;
        cmp(16'(cur), 16'(e));
    endtask
    task automatic fields();
        repeat (8) begin
            @(posedge clk);
            fstart <= 1'b1;
        end
        @(posedge clk);
        fstart <= 1'b0;
    endtask
    task automatic t_geom();
        host_u.reg_wr(5'h02, 8'h5A);
        cmp(16'(hsp), 16'h005A);
        host_u.reg_wr(5'h06, 8'hD9);
        cmp(16'(vdsp), 16'h0059);
        host_u.reg_wr(5'h07, 8'h9C);
        cmp(16'(vsp), 16'h001C);
        host_u.reg_wr(5'h0E, 8'hC1);
        host_u.reg_wr(5'h0F, 8'h23);
        cmp(16'(caddr), 16'h0123);
        host_u.reg_wr(5'h0A, 8'h07);
        host_u.reg_wr(5'h0B, 8'h03);
        cur_at(1'b1, 5'h05, 1'b0);
        cur_at(1'b1, 5'h02, 1'b1);
        cur_at(1'b1, 5'h09, 1'b1);
        cur_at(1'b0, 5'h09, 1'b0);
        host_u.reg_wr(5'h0B, 8'h1F);
        cur_at(1'b1, 5'h05, 1'b1);
        host_u.reg_wr(5'h0A, 8'h1E);
        cur_at(1'b1, 5'h05, 1'b0);
        host_u.reg_wr(5'h0A, 8'h22);
        cur_at(1'b1, 5'h05, 1'b0);
        host_u.reg_wr(5'h0A, 8'h62);
        cur_at(1'b1, 5'h05, 1'b1);
        fields();
        cur_at(1'b1, 5'h05, 1'b0);
        host_u.reg_wr(5'h0A, 8'h02);
        cur_at(1'b1, 5'h05, 1'b0);
        fields();
        cur_at(1'b1, 5'h05, 1'b1);
        host_u.reg_wr(5'h0A, 8'h62);
        cur_at(1'b1, 5'h05, 1'b0);
        @(posedge clk);
        amatch <= 1'b0;
        $display("t_geom done");
    endtask
    task automatic t_bank();
        @(posedge clk);
        bank_seln <= 1'b0;
        bank(6'h2A, 8'h01);
        cmp(16'(var_sel), 16'h0000);
        host_u.wr(4'hF, 8'h80);
        @(posedge clk);
        bank_seln <= 1'b1;
        bank(6'h2A, 8'h01);
        cmp(16'(var_sel), 16'h0000);
        @(posedge clk);
        bank_seln <= 1'b0;
        bank(6'h2A, 8'h01);
        cmp(16'(var_sel), 16'h0001);
        host_u.reg_wr(5'h03, 8'hA5);
        cmp(16'(vw), 16'h000A);
        host_u.reg_wr(5'h03, 8'h05);
        cmp(16'(vw), 16'h0010);
        host_u.reg_wr(5'h04, 8'hFF);
        cmp(16'(vtot), 16'h00FF);
        host_u.wr(4'h8, 8'h2C);
        host_u.wr(4'h9, 8'h15);
        bank(6'h29, 8'h40);
        rdchk(4'h8, 9'h12C);
        rdchk(4'h9, 9'h115);
        cmp(16'(csel), 16'h0015);
        cmp(16'(bptr), 16'h0029);
        do_reset();
        cmp(16'(var_sel), 16'h0000);
        rdchk(4'h8, 9'h000);
        $display("t_bank done");
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_sim();
    end
    initial begin
        do_reset();
        t_reset();
        t_addr();
        t_horiz();
        t_pen();
        t_geom();
        t_bank();
        end_sim();
    end
endmodule

/* hw/crtr_cfg.svh */
// Register offsets, field positions and reset values of the raster timing register set.
`ifndef CRTR_CFG_SVH
`define CRTR_CFG_SVH
`define CRTR_PORT_MODE 4'h8
`define CRTR_PORT_COLOUR 4'h9
`define CRTR_PORT_STATUS 4'hA
`define CRTR_PORT_PEN_CLEAR 4'hB
`define CRTR_PORT_PEN_PRESET 4'hC
`define CRTR_PORT_BANK_PTR 4'hD
`define CRTR_PORT_BANK_VAL 4'hE
`define CRTR_PORT_CTRL_ID 4'hF
`define CRTR_IDX_HTOTAL 5'h00
`define CRTR_IDX_HDISP 5'h01
`define CRTR_IDX_HSYNC_POS 5'h02
`define CRTR_IDX_SYNC_WIDTHS 5'h03
`define CRTR_IDX_VTOTAL 5'h04
`define CRTR_IDX_VADJUST 5'h05
`define CRTR_IDX_VDISP 5'h06
`define CRTR_IDX_VSYNC_POS 5'h07
`define CRTR_IDX_SCAN_MODE 5'h08
`define CRTR_IDX_RASTERS 5'h09
`define CRTR_IDX_CUR_START 5'h0A
`define CRTR_IDX_CUR_END 5'h0B
`define CRTR_IDX_START_HI 5'h0C
`define CRTR_IDX_CURSOR_LO 5'h0F
`define CRTR_IDX_PEN_HI 5'h10
`define CRTR_IDX_LAST 5'h11
`define CRTR_BANK_READBACK_IDX 6'h29
`define CRTR_BANK_READBACK_BIT 6
`define CRTR_BANK_VARIANT_IDX 6'h2A
`define CRTR_BANK_VARIANT_BIT 0
`define CRTR_CTRL_PROTECT_BIT 7
`define CRTR_MODE_HIRES_TEXT_BIT 0
`define CRTR_STATUS_PEN_BIT 1
`define CRTR_VSYNC_FIXED 5'h10
`define CRTR_BYTE_RESET 8'h00
`endif

/* hw/crtr_cursor.sv */
// Cursor raster shape and field blink evaluation.
`timescale 1ns/1ns
module crtr_cursor
    import crtr_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // Raster position
    input wire logic i_field_start,
    input wire logic [4:0] i_raster,
    input wire logic i_addr_match,
    // Cursor settings
    input wire logic [4:0] i_start,
    input wire logic [4:0] i_end,
    input wire logic [4:0] i_max_raster,
    input wire logic [1:0] i_blink,
    // Result
    output logic o_cursor_on
);
    logic [4:0] field_cnt_q;
    logic shape_hit;
    logic blink_on;
    crtr_blink_t blink_mode;

    assign blink_mode = crtr_blink_t'(i_blink);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            field_cnt_q <= 5'h00;
        end else if (i_ce && i_field_start) begin
            field_cnt_q <= field_cnt_q + 5'h01;
        end
    end

    always_comb begin
        if (i_start > i_max_raster) begin
            shape_hit = 1'b0;
        end else if (i_end > i_max_raster) begin
            shape_hit = 1'b1;
        end else if (i_start > i_end) begin
            shape_hit = (i_raster <= i_end) || (i_raster >= i_start);
        end else begin
            shape_hit = (i_raster >= i_start) && (i_raster <= i_end);
        end
    end

    always_comb begin
        case (blink_mode)
            CRTR_BLINK_HIDDEN: blink_on = 1'b0;
            CRTR_BLINK_SLOW: blink_on = (field_cnt_q[4:3] == 2'h0);
            default: blink_on = !field_cnt_q[3];
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_cursor_on <= 1'b0;
        end else if (i_ce) begin
            o_cursor_on <= i_addr_match && shape_hit && blink_on;
        end
    end
endmodule

/* hw/crtr_pkg.sv */
// Shared types of the raster timing register set.
package crtr_pkg;
    typedef logic [7:0] crtr_byte_t;
    typedef enum logic [1:0] {
        CRTR_BLINK_FAST_A,
        CRTR_BLINK_HIDDEN,
        CRTR_BLINK_FAST_B,
        CRTR_BLINK_SLOW
    } crtr_blink_t;
endpackage

/* hw/crtr_regs.sv */
// Host I/O port decoder and raster timing register set of the display controller.
// Contract
// - Four low address lines select sixteen ports.
// - Index port points at timing registers 0-17.
// - Write strobe stores, read strobe drives bus.
// - Drive bus only for listed readable ports.
// - Write-only read: high impedance, direction zero.
// - Bank writes need select low, protect set.
// - Port B clears pen flag; personality presets.
// - Even horizontal total rounds up to odd when required.
// - Odd displayed count rounds down in high-res.
// - Horizontal sync position is index minus one.
// - Horizontal sync width 1-15, never zero; a zero is passed through unchanged.
// - Vertical sync width programmable or fixed 16.
// - Vertical total and displayed rows stored.
// - Extra scan lines per field, 0-31.
// - Vertical sync row is target minus one.
// - Vertical bit seven forced zero unless variant.
// - Scan mode bit selects interlace.
// - Rasters per row minus one stored.
// - Cursor start raster and blink mode.
// - Cursor shape from start, end, maximum raster.
// - Start and cursor addresses are 14 bits.
// - Pen strobe rising edge latches refresh address.
// - Variant select is zero after reset.
`timescale 1ns/1ns
`include "crtr_cfg.svh"
module crtr_regs
    import crtr_pkg::*;
#(
    parameter int ADDR_W = 14,
    parameter int REG_COUNT = 18
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // Host I/O port
    input wire logic [3:0] i_port_select_lines,
    input wire logic [7:0] i_host_data_bus,
    output logic [7:0] o_host_data_bus,
    output logic o_host_data_oe,
    output logic o_bus_direction,
    input wire logic i_io_write_strobe,
    input wire logic i_io_read_strobe,
    input wire logic i_bank_port_selectn,
    // Personality and raster engine feedback
    input wire logic i_mono_personality,
    input wire logic i_pen_strobe,
    input wire logic [ADDR_W-1:0] i_refresh_addr,
    input wire logic i_field_start,
    input wire logic [4:0] i_raster,
    input wire logic i_cursor_addr_match,
    // Timing values to the raster engine
    output logic [7:0] o_htotal,
    output logic [7:0] o_hdisp,
    output logic [7:0] o_hsync_pos,
    output logic [3:0] o_hsync_width,
    output logic [4:0] o_vsync_width,
    output logic [7:0] o_vtotal,
    output logic [4:0] o_vadjust,
    output logic [7:0] o_vdisp,
    output logic [7:0] o_vsync_pos,
    output logic o_interlace,
    output logic [4:0] o_max_raster,
    output logic [ADDR_W-1:0] o_start_addr,
    output logic [ADDR_W-1:0] o_cursor_addr,
    output logic o_cursor_on,
    // Mode, colour and bank values to the rest of the controller
    output logic [7:0] o_operating_mode,
    output logic [7:0] o_colour_select,
    output logic [7:0] o_control_identity,
    output logic [5:0] o_bank_pointer,
    output logic [7:0] o_bank_value,
    output logic o_bank_write,
    output logic o_compat_variant_select,
    output logic o_pen_flag
);
    initial begin
        if (ADDR_W != 14) begin
            $error("crtr_regs supports only a 14-bit refresh address");
        end
        if (REG_COUNT != 18) begin
            $error("crtr_regs supports only 18 timing registers");
        end
    end

    crtr_byte_t timing_q [REG_COUNT];
    logic [4:0] timing_index_q;
    crtr_byte_t operating_mode_q;
    crtr_byte_t colour_select_q;
    crtr_byte_t control_identity_q;
    logic [5:0] bank_ptr_q;
    crtr_byte_t bank_val_q;
    logic bank_write_q;
    logic readback_enable_q;
    logic compat_variant_select_q;
    logic pen_flag_q;
    logic pen_strobe_prev_q;
    logic [ADDR_W-1:0] pen_addr_q;
    logic wr;
    logic rd;
    logic is_index_port;
    logic is_data_port;
    logic bank_ok;
    logic pen_rise;
    logic pen_preset;
    crtr_byte_t wr_byte;
    crtr_byte_t rd_byte;
    logic rd_valid;
    logic hires_text;

    // Even ports of the low half are the index, odd ports the data.
    function automatic logic low_half(input logic [3:0] port);
        return !port[3];
    endfunction

    function automatic logic is_vertical_idx(input logic [4:0] idx);
        return idx == `CRTR_IDX_VTOTAL
            || idx == `CRTR_IDX_VDISP
            || idx == `CRTR_IDX_VSYNC_POS;
    endfunction

    assign wr = i_ce && i_io_write_strobe;
    assign rd = i_io_read_strobe;
    assign is_index_port = low_half(i_port_select_lines) && !i_port_select_lines[0];
    assign is_data_port = low_half(i_port_select_lines) && i_port_select_lines[0];
    assign bank_ok = !i_bank_port_selectn && control_identity_q[`CRTR_CTRL_PROTECT_BIT];
    assign pen_rise = i_pen_strobe && !pen_strobe_prev_q;
    assign hires_text = operating_mode_q[`CRTR_MODE_HIRES_TEXT_BIT];
    assign pen_preset = wr
        && ((!i_mono_personality && i_port_select_lines == `CRTR_PORT_PEN_PRESET)
        || (i_mono_personality && i_port_select_lines == `CRTR_PORT_COLOUR));

    // The vertical top bit cannot be set in the original personality.
    always_comb begin
        wr_byte = i_host_data_bus;
        if (is_vertical_idx(timing_index_q) && !compat_variant_select_q) begin
            wr_byte[7] = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            timing_index_q <= 5'h00;
        end else if (wr && is_index_port) begin
            timing_index_q <= i_host_data_bus[4:0];
        end
    end

    // The light-pen pair is read-only, so data writes at index 16 and up are dropped.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                timing_q[i] <= `CRTR_BYTE_RESET;
            end
        end else if (wr && is_data_port && timing_index_q < `CRTR_IDX_PEN_HI) begin
            timing_q[timing_index_q] <= wr_byte;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            operating_mode_q <= `CRTR_BYTE_RESET;
            colour_select_q <= `CRTR_BYTE_RESET;
            control_identity_q <= `CRTR_BYTE_RESET;
        end else if (wr) begin
            if (i_port_select_lines == `CRTR_PORT_MODE) begin
                operating_mode_q <= i_host_data_bus;
            end else if (i_port_select_lines == `CRTR_PORT_COLOUR) begin
                colour_select_q <= i_host_data_bus;
            end else if (i_port_select_lines == `CRTR_PORT_CTRL_ID) begin
                control_identity_q <= i_host_data_bus;
            end
        end
    end

    // The bank write pulse stands for one enabled cycle per accepted data byte.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            bank_ptr_q <= 6'h00;
            bank_val_q <= `CRTR_BYTE_RESET;
            bank_write_q <= 1'b0;
        end else if (i_ce) begin
            bank_write_q <= 1'b0;
            if (i_io_write_strobe && bank_ok) begin
                if (i_port_select_lines == `CRTR_PORT_BANK_PTR) begin
                    bank_ptr_q <= i_host_data_bus[5:0];
                end else if (i_port_select_lines == `CRTR_PORT_BANK_VAL) begin
                    bank_val_q <= i_host_data_bus;
                    bank_write_q <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            readback_enable_q <= 1'b0;
            compat_variant_select_q <= 1'b0;
        end else if (wr && bank_ok && i_port_select_lines == `CRTR_PORT_BANK_VAL) begin
            if (bank_ptr_q == `CRTR_BANK_READBACK_IDX) begin
                readback_enable_q <= i_host_data_bus[`CRTR_BANK_READBACK_BIT];
            end else if (bank_ptr_q == `CRTR_BANK_VARIANT_IDX) begin
                compat_variant_select_q <= i_host_data_bus[`CRTR_BANK_VARIANT_BIT];
            end
        end
    end

    // The edge detector resets to the idle low strobe level, so a strobe already high after reset is captured.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pen_strobe_prev_q <= 1'b0;
            pen_addr_q <= '0;
        end else if (i_ce) begin
            pen_strobe_prev_q <= i_pen_strobe;
            if (pen_rise) begin
                pen_addr_q <= i_refresh_addr;
            end
        end
    end

    // A capture or preset in the same cycle as a clear leaves the flag set.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pen_flag_q <= 1'b0;
        end else if (i_ce) begin
            if ((pen_rise) || pen_preset) begin
                pen_flag_q <= 1'b1;
            end else if (wr && i_port_select_lines == `CRTR_PORT_PEN_CLEAR) begin
                pen_flag_q <= 1'b0;
            end
        end
    end

    // Read mux; only the data port, status, control and enabled mode/colour answer.
    always_comb begin
        rd_byte = 8'h00;
        rd_valid = 1'b0;
        if (is_data_port) begin
            rd_valid = 1'b1;
            if (timing_index_q == `CRTR_IDX_PEN_HI) begin
                rd_byte = {2'h0, pen_addr_q[13:8]};
            end else if (timing_index_q == `CRTR_IDX_LAST) begin
                rd_byte = pen_addr_q[7:0];
            end else if (timing_index_q >= `CRTR_IDX_START_HI &&
                    timing_index_q <= `CRTR_IDX_CURSOR_LO) begin
                rd_byte = timing_q[timing_index_q];
            end
        end else if (i_port_select_lines == `CRTR_PORT_MODE) begin
            rd_valid = readback_enable_q;
            rd_byte = operating_mode_q;
        end else if (i_port_select_lines == `CRTR_PORT_COLOUR) begin
            rd_valid = readback_enable_q;
            rd_byte = colour_select_q;
        end else if (i_port_select_lines == `CRTR_PORT_STATUS) begin
            rd_valid = 1'b1;
            rd_byte[`CRTR_STATUS_PEN_BIT] = pen_flag_q;
        end else if (i_port_select_lines == `CRTR_PORT_CTRL_ID) begin
            rd_valid = 1'b1;
            rd_byte = control_identity_q;
        end
    end

    assign o_host_data_oe = rd && rd_valid;
    assign o_bus_direction = rd && rd_valid;
    assign o_host_data_bus = o_host_data_oe ? rd_byte : 8'h00;

    // Effective horizontal values after the even-count corrections.
    always_comb begin
        o_htotal = timing_q[`CRTR_IDX_HTOTAL];
        if ((o_interlace || hires_text) && !o_htotal[0]) begin
            o_htotal = o_htotal | 8'h01;
        end
        o_hdisp = timing_q[`CRTR_IDX_HDISP];
        if (hires_text) begin
            o_hdisp[0] = 1'b0;
        end
    end

    assign o_hsync_pos = timing_q[`CRTR_IDX_HSYNC_POS];
    assign o_hsync_width = timing_q[`CRTR_IDX_SYNC_WIDTHS][3:0];
    assign o_vsync_width = (!compat_variant_select_q ||
        timing_q[`CRTR_IDX_SYNC_WIDTHS][7:4] == 4'h0) ? `CRTR_VSYNC_FIXED
        : {1'b0, timing_q[`CRTR_IDX_SYNC_WIDTHS][7:4]};
    assign o_vtotal = timing_q[`CRTR_IDX_VTOTAL];
    assign o_vadjust = timing_q[`CRTR_IDX_VADJUST][4:0];
    assign o_vdisp = timing_q[`CRTR_IDX_VDISP];
    assign o_vsync_pos = timing_q[`CRTR_IDX_VSYNC_POS];
    assign o_interlace = timing_q[`CRTR_IDX_SCAN_MODE][0];
    assign o_max_raster = timing_q[`CRTR_IDX_RASTERS][4:0];
    assign o_start_addr = {timing_q[`CRTR_IDX_START_HI][5:0],
        timing_q[`CRTR_IDX_START_HI + 5'h01]};
    assign o_cursor_addr = {timing_q[`CRTR_IDX_CURSOR_LO - 5'h01][5:0],
        timing_q[`CRTR_IDX_CURSOR_LO]};
    assign o_operating_mode = operating_mode_q;
    assign o_colour_select = colour_select_q;
    assign o_control_identity = control_identity_q;
    assign o_bank_pointer = bank_ptr_q;
    assign o_bank_value = bank_val_q;
    assign o_bank_write = bank_write_q;
    assign o_compat_variant_select = compat_variant_select_q;
    assign o_pen_flag = pen_flag_q;

    crtr_cursor u_cursor (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_field_start(i_field_start),
        .i_raster(i_raster),
        .i_addr_match(i_cursor_addr_match),
        .i_start(timing_q[`CRTR_IDX_CUR_START][4:0]),
        .i_end(timing_q[`CRTR_IDX_CUR_END][4:0]),
        .i_max_raster(o_max_raster),
        .i_blink(timing_q[`CRTR_IDX_CUR_START][6:5]),
        .o_cursor_on(o_cursor_on)
    );
endmodule
